//--- common/led_pin_defines.svh
`ifndef LED_PIN_DEFINES_SVH
`define LED_PIN_DEFINES_SVH
`define LED_PIN_CONFIG_ADDR  12'h024
`define MAP_SEL_BIT          31
`define PIN10_FN_LSB         24
`define PIN9_FN_LSB          20
`define PIN8_FN_LSB          16
`define DRIVE_LSB            8
`define DIR_LSB              4
`define LEVEL_LSB            0
`define FN_RESET             2'h0
`define BITS3_RESET          3'h0
`define MAP_SEL_RESET        1'h0
`define OE_N_RESET           3'h7
`endif

//--- common/led_pin_pkg.sv
package led_pin_pkg;
  typedef enum logic [1:0] {
    FN_GPIO   = 2'b00,
    FN_LED    = 2'b01,
    FN_MIRROR = 2'b10,
    FN_ALT    = 2'b11
  } pin_fn_e;

  typedef struct packed {
    logic       map_sel;
    logic       eeprom_val;
    pin_fn_e    fn10;
    pin_fn_e    fn9;
    pin_fn_e    fn8;
    logic [2:0] drive;
    logic [2:0] dir;
    logic [2:0] level_out;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] level_in;
    logic [2:0] pin_o;
    logic [2:0] pin_oe_n;
    logic       pready;
    logic [31:0] prdata;
    logic       pslverr;
  } state_s;
endpackage

//--- src/led_pin_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "led_pin_defines.svh"

module led_pin_config (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        eeprom_present,
  input  wire logic        eeprom_led_select,
  input  wire logic        eeprom_load_done,
  input  wire logic        usb_reset,
  input  wire logic        lite_reset,
  input  wire logic        link_speed_100,
  input  wire logic        link_up,
  input  wire logic        link_activity,
  input  wire logic        full_duplex,
  input  wire logic [3:0]  mii_rx_data,
  input  wire logic        mii_carrier_sense,
  input  wire logic        phy_reset_output,
  input  wire logic [2:0]  pin_i,
  output logic [2:0]       pin_o,
  output logic [2:0]       pin_oe_n
);

  led_pin_pkg::state_s st;
  led_pin_pkg::state_s next_st;

  logic led_speed_n;
  logic led_link_n;
  logic led_third_n;
  logic [2:0] fn_drive;
  logic [2:0] fn_val;
  logic       acc;
  logic       hit;
  logic [31:0] rd_word;

  // active-low LED levels from the current mapping select
  always_comb begin
    led_speed_n = ~link_speed_100;
    if (st.map_sel) begin
      led_link_n  = ~link_up;
      led_third_n = ~link_activity;
    end else begin
      led_link_n  = ~(link_up & ~link_activity); // blinks off on traffic
      // hardware gives activity; full duplex is software's job
      led_third_n = ~link_activity;
    end
  end

  // per-pin function: is it a hardware source, and its value
  function automatic logic [1:0] pin_src(input led_pin_pkg::pin_fn_e fn,
                                         input logic led_v,
                                         input logic mir_v,
                                         input logic alt_v);
    case (fn)
      led_pin_pkg::FN_GPIO:   pin_src = 2'h0;
      led_pin_pkg::FN_LED:    pin_src = {1'b1, led_v};
      led_pin_pkg::FN_MIRROR: pin_src = {1'b1, mir_v};
      led_pin_pkg::FN_ALT:    pin_src = {1'b1, alt_v};
      default:                pin_src = 2'h0;
    endcase
  endfunction

  // pin 8 shows the third LED, pin 9 link, pin 10 speed
  always_comb begin
    {fn_drive[0], fn_val[0]} = pin_src(st.fn8, led_third_n,
                                       mii_rx_data[2],
                                       mii_carrier_sense);
    {fn_drive[1], fn_val[1]} = pin_src(st.fn9, led_link_n,
                                       mii_rx_data[1],
                                       phy_reset_output);
    {fn_drive[2], fn_val[2]} = pin_src(st.fn10, led_speed_n,
                                       mii_rx_data[0],
                                       mii_rx_data[3]);
  end

  // register image; reserved bits stay zero
  always_comb begin
    rd_word = 32'h0;
    rd_word[`MAP_SEL_BIT] = st.map_sel;
    rd_word[`PIN10_FN_LSB +: 2] = st.fn10;
    rd_word[`PIN9_FN_LSB +: 2] = st.fn9;
    rd_word[`PIN8_FN_LSB +: 2] = st.fn8;
    rd_word[`DRIVE_LSB +: 3] = st.drive;
    rd_word[`DIR_LSB +: 3] = st.dir;
    rd_word[`LEVEL_LSB +: 3] = st.level_in; // live pin state
  end

  assign acc = psel & penable & ~st.pready;
  assign hit = (paddr == `LED_PIN_CONFIG_ADDR);

  // next state: bus, resets from other blocks, pin drivers
  always_comb begin
    logic drv;
    logic val;
    drv = 1'b0;
    val = 1'b0;
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    // level synchroniser, change taken when stages two and three agree
    next_st.sync1 = pin_i;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    for (int i = 0; i < 3; i++) begin
      if (st.sync2[i] == st.sync3[i]) begin
        next_st.level_in[i] = st.sync3[i];
      end
    end
    if (eeprom_load_done) begin
      next_st.eeprom_val = eeprom_present & eeprom_led_select;
      next_st.map_sel = eeprom_present & eeprom_led_select;
    end
    // one-cycle wait state: answer in the cycle after access starts
    if (acc) begin
      next_st.pready = 1'b1;
      next_st.pslverr = ~hit;
      next_st.prdata = 32'h0;
      if (hit && !pwrite) begin
        next_st.prdata = rd_word;
      end
      if (hit && pwrite) begin
        if (pstrb[3]) begin
          next_st.map_sel = pwdata[`MAP_SEL_BIT];
          next_st.fn10 = led_pin_pkg::pin_fn_e'(
                           pwdata[`PIN10_FN_LSB +: 2]);
        end
        if (pstrb[2]) begin
          next_st.fn9 = led_pin_pkg::pin_fn_e'(
                          pwdata[`PIN9_FN_LSB +: 2]);
          next_st.fn8 = led_pin_pkg::pin_fn_e'(
                          pwdata[`PIN8_FN_LSB +: 2]);
        end
        if (pstrb[1]) begin
          next_st.drive = pwdata[`DRIVE_LSB +: 3];
        end
        if (pstrb[0]) begin
          next_st.dir = pwdata[`DIR_LSB +: 3];
          next_st.level_out = pwdata[`LEVEL_LSB +: 3];
        end
      end
    end
    // usb or lite reset wins over a write in the same cycle
    if (usb_reset || lite_reset) begin
      next_st.map_sel = st.eeprom_val;
    end
    // pin drive: function source or GPIO output, then buffer type
    for (int i = 0; i < 3; i++) begin
      drv = fn_drive[i] | st.dir[i];
      val = fn_drive[i] ? fn_val[i] : st.level_out[i];
      next_st.pin_o[i] = val;
      if (!drv) begin
        next_st.pin_oe_n[i] = 1'b1;
        next_st.pin_o[i] = 1'b0; // released: park the level low
      end else if (st.drive[i]) begin
        next_st.pin_oe_n[i] = 1'b0; // push-pull
      end else begin
        next_st.pin_oe_n[i] = val; // open-drain pulls low only
        next_st.pin_o[i] = 1'b0;
      end
    end
  end

  // all state in one register, frozen while clk_en is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.fn10 <= led_pin_pkg::pin_fn_e'(`FN_RESET);
      st.fn9 <= led_pin_pkg::pin_fn_e'(`FN_RESET);
      st.fn8 <= led_pin_pkg::pin_fn_e'(`FN_RESET);
      st.drive <= `BITS3_RESET;
      st.dir <= `BITS3_RESET;
      st.map_sel <= `MAP_SEL_RESET;
      st.pin_oe_n <= `OE_N_RESET;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign pready = st.pready;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr;
  assign pin_o = st.pin_o;
  assign pin_oe_n = st.pin_oe_n;

  // a write of select reaches the register one edge later
  property p_sel_write;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && acc && hit && pwrite && pstrb[3] && !usb_reset
     && !lite_reset && !eeprom_load_done)
    |=> (st.map_sel == $past(pwdata[31]));
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("mapping select not written");

  property p_eeprom_load;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && eeprom_load_done && !usb_reset && !lite_reset
     && !(acc && hit && pwrite && pstrb[3]))
    |=> (st.map_sel == $past(eeprom_present & eeprom_led_select));
  endproperty
  a_eeprom_load: assert property (p_eeprom_load)
    else $error("mapping select not taken from eeprom");

  property p_soft_reset;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && (usb_reset || lite_reset))
    |=> (st.map_sel == $past(st.eeprom_val));
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset did not restore select");

  property p_mirror9;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && st.fn9 == led_pin_pkg::FN_MIRROR && st.drive[1])
    |=> (pin_o[1] == $past(mii_rx_data[1]) && !pin_oe_n[1]);
  endproperty
  a_mirror9: assert property (p_mirror9)
    else $error("pin 9 not mirroring receive line");

  property p_input_released;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && !st.dir[0] && st.fn8 == led_pin_pkg::FN_GPIO)
    |=> pin_oe_n[0];
  endproperty
  a_input_released: assert property (p_input_released)
    else $error("input pin driven");

  property p_open_drain;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && !st.drive[2]) |=> (pin_o[2] == 1'b0);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain pin driven high");

  property p_read_level;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && acc && hit && !pwrite)
    |=> (pready && prdata[2:0] == $past(st.level_in)
         && prdata[30:26] == 5'h0);
  endproperty
  a_read_level: assert property (p_read_level)
    else $error("read data wrong");

  property p_led_follow;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && st.fn8 == led_pin_pkg::FN_LED && st.drive[0]
     && st.map_sel)
    |=> (pin_o[0] == !$past(link_activity));
  endproperty
  a_led_follow: assert property (p_led_follow)
    else $error("pin 8 LED not following select");

  // pin 10 mirror codes: receive lines 0 and 3
  property p_mirror10;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && st.fn10 == led_pin_pkg::FN_MIRROR && st.drive[2])
    |=> (pin_o[2] == $past(mii_rx_data[0]) && !pin_oe_n[2]);
  endproperty
  a_mirror10: assert property (p_mirror10)
    else $error("pin 10 not mirroring receive line 0");

  property p_mirror10_hi;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && st.fn10 == led_pin_pkg::FN_ALT && st.drive[2])
    |=> (pin_o[2] == $past(mii_rx_data[3]) && !pin_oe_n[2]);
  endproperty
  a_mirror10_hi: assert property (p_mirror10_hi)
    else $error("pin 10 not mirroring receive line 3");

  // pin 9 code 11 carries the PHY reset out
  property p_phy_reset9;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && st.fn9 == led_pin_pkg::FN_ALT && st.drive[1])
    |=> (pin_o[1] == $past(phy_reset_output) && !pin_oe_n[1]);
  endproperty
  a_phy_reset9: assert property (p_phy_reset9)
    else $error("pin 9 not showing PHY reset");

  property p_carrier8;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && st.fn8 == led_pin_pkg::FN_ALT && st.drive[0])
    |=> (pin_o[0] == $past(mii_carrier_sense) && !pin_oe_n[0]);
  endproperty
  a_carrier8: assert property (p_carrier8)
    else $error("pin 8 not mirroring carrier sense");

  property p_mirror8;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && st.fn8 == led_pin_pkg::FN_MIRROR && st.drive[0])
    |=> (pin_o[0] == $past(mii_rx_data[2]) && !pin_oe_n[0]);
  endproperty
  a_mirror8: assert property (p_mirror8)
    else $error("pin 8 not mirroring receive line 2");

  // LEDs are active low: lit means the pin is pulled low
  property p_speed10;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && st.fn10 == led_pin_pkg::FN_LED && st.drive[2])
    |=> (pin_o[2] == !$past(link_speed_100));
  endproperty
  a_speed10: assert property (p_speed10)
    else $error("pin 10 not showing speed");

  // link LED: steady under select 1, blinks on traffic under 0
  property p_link9;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && st.fn9 == led_pin_pkg::FN_LED && st.drive[1])
    |=> (pin_o[1] == !($past(link_up)
         && ($past(st.map_sel) || !$past(link_activity))));
  endproperty
  a_link9: assert property (p_link9)
    else $error("pin 9 LED not following select");

  // plain GPIO output, push-pull: written level reaches the pin
  property p_gpio_out;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && st.fn8 == led_pin_pkg::FN_GPIO && st.dir[0] && st.drive[0])
    |=> (pin_o[0] == $past(st.level_out[0]) && !pin_oe_n[0]);
  endproperty
  a_gpio_out: assert property (p_gpio_out)
    else $error("pin 8 output level not driven");

  // open drain pulls low for a 0 and lets go for a 1
  property p_open_drain_low;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && st.fn8 == led_pin_pkg::FN_GPIO && st.dir[0] && !st.drive[0])
    |=> (pin_oe_n[0] == $past(st.level_out[0]));
  endproperty
  a_open_drain_low: assert property (p_open_drain_low)
    else $error("pin 8 open-drain enable wrong");

  // a write of the pin 9 code lands one edge later
  property p_fn9_write;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && acc && hit && pwrite && pstrb[2])
    |=> (st.fn9 == $past(pwdata[21:20]));
  endproperty
  a_fn9_write: assert property (p_fn9_write)
    else $error("pin 9 code not written");

  // unmapped address answers with an error and no data
  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && acc && !hit)
    |=> (pready && pslverr && prdata == 32'h0);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

endmodule
`default_nettype wire

//--- verif/pin_board.sv
`timescale 1ns/1ps
`default_nettype none
// board side: pull-ups on all pins, optional external driver
module pin_board (
  input  wire logic [2:0] pin_o,
  input  wire logic [2:0] pin_oe_n,
  input  wire logic [2:0] ext_en,
  input  wire logic [2:0] ext_val,
  output logic [2:0]      pin_level
);
  // released pin takes the external driver if enabled, else the pull-up; never keeps the old value
  // external drive only meant for pins set as inputs
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_level[i] = !pin_oe_n[i] ? pin_o[i] :
                     (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [11:0] A = 12'h024;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, e;
  logic        ee_p = 1'b0, ee_s = 1'b0, ee_ld = 1'b0;
  logic        usb = 1'b0, lite = 1'b0, spd = 1'b0;
  logic        lnk = 1'b0, act = 1'b0, crs = 1'b0, phy = 1'b0;
  logic [3:0]  rx = 4'h0;
  logic [3:0]  strb = 4'hF;
  logic        ce = 1'b1;
  logic [2:0]  pin_o, oe_n, lvl, ext_en = 3'h0, ext_v = 3'h0, x;
  int          num_errors = 0;
  int          samples_checked = 0;

  always #12.5 pclk = ~pclk;

  led_pin_config dut_u (.pclk(pclk), .presetn(presetn), .clk_en(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(strb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .eeprom_present(ee_p), .eeprom_led_select(ee_s),
    .eeprom_load_done(ee_ld), .usb_reset(usb), .lite_reset(lite),
    .link_speed_100(spd), .link_up(lnk), .link_activity(act),
    .full_duplex(1'b0), .mii_rx_data(rx), .mii_carrier_sense(crs),
    .phy_reset_output(phy), .pin_i(lvl), .pin_o(pin_o), .pin_oe_n(oe_n));

  pin_board brd_u (.pin_o(pin_o), .pin_oe_n(oe_n), .ext_en(ext_en),
    .ext_val(ext_v), .pin_level(lvl));

  task automatic chk(input logic [31:0] g, input logic [31:0] x0,
                     input string m);
    samples_checked++;
    if (g !== x0) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, x0);
    end
  endtask

  // one apb transfer; entered right after a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // idle edge, so a following call never re-drives psel in one step
    @(posedge pclk);
    if (n >= 40) chk(32'h1, 32'h0, "no pready");
  endtask

  // pin inputs pass three sync flops, so settle before sampling
  task automatic st();
    repeat (6) @(posedge pclk);
  endtask

  task automatic rd(input logic [31:0] x0, input string m);
    apb(1'b0, A, 32'h0);
    chk(r, x0, m);
  endtask

  task automatic sel(input logic x0, input string m);
    apb(1'b0, A, 32'h0);
    chk({31'h0, r[31]}, {31'h0, x0}, m);
  endtask

  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    st();
    rd(32'h0000_0007, "reset value");
    apb(1'b1, 12'h028, 32'hFFFF_FFFF);
    chk({31'h0, e}, 32'h1, "unmapped");
    // reserved ones must vanish, push-pull outputs drive 101
    apb(1'b1, A, 32'h7CCC_FFFD);
    st();
    chk({29'h0, lvl}, 32'h5, "push-pull");
    rd(32'h0000_0775, "reserved");
    apb(1'b1, A, 32'h0000_0072);
    st();
    chk({26'h0, oe_n, pin_o}, 32'h10, "open drain");
    ext_en <= 3'h7; ext_v <= 3'h3;
    apb(1'b1, A, 32'h0000_0007);
    st();
    chk({29'h0, oe_n}, 32'h7, "input dir");
    rd(32'h0000_0003, "pin read");
    ext_en <= 3'h0;
    // led codes under both mapping selects
    for (int k = 0; k < 16; k++) begin
      spd <= k[0]; lnk <= k[1]; act <= k[2];
      apb(1'b1, A, {k[3], 31'h0111_0770});
      st();
      x = {~k[0], ~(k[1] & (k[3] | ~k[2])), ~k[2]};
      chk({29'h0, lvl}, {29'h0, x}, "led map");
    end
    // mirror codes follow live internal signals
    for (int k = 0; k < 32; k++) begin
      rx <= k[4:1]; crs <= ~k[1]; phy <= k[2] ^ k[3];
      apb(1'b1, A, k[0] ? 32'h0333_0770 : 32'h0222_0770);
      st();
      x = k[0] ? {k[4], k[2] ^ k[3], ~k[1]} : {k[1], k[2], k[3]};
      chk({29'h0, lvl}, {29'h0, x}, "mirror");
    end
    ee_p <= 1'b1; ee_s <= 1'b1; ee_ld <= 1'b1;
    @(posedge pclk);
    ee_ld <= 1'b0;
    sel(1'b1, "eeprom load");
    apb(1'b1, A, 32'h0);
    sel(1'b0, "select write");
    usb <= 1'b1;
    @(posedge pclk);
    usb <= 1'b0;
    sel(1'b1, "usb restore");
    apb(1'b1, A, 32'h0);
    lite <= 1'b1;
    @(posedge pclk);
    lite <= 1'b0;
    sel(1'b1, "lite restore");
    ee_p <= 1'b0; ee_ld <= 1'b1;
    @(posedge pclk);
    ee_ld <= 1'b0;
    sel(1'b0, "no eeprom");
    apb(1'b1, A, 32'h8000_0000);
    usb <= 1'b1;
    @(posedge pclk);
    usb <= 1'b0;
    sel(1'b0, "usb no eeprom");
    // byte strobes: only the enabled lanes may change
    strb <= 4'h6;
    apb(1'b1, A, 32'hFFFF_FFFF);
    strb <= 4'hF;
    st();
    rd(32'h0033_0704, "byte strobes");
    // clock enable low: an eeprom load pulse must not land
    ce <= 1'b0; ee_p <= 1'b1; ee_ld <= 1'b1;
    @(posedge pclk);
    ee_ld <= 1'b0;
    @(posedge pclk);
    ce <= 1'b1;
    sel(1'b0, "frozen");
    test_done();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(25 * 20000);
    num_errors++;
    test_done();
  end
endmodule
`default_nettype wire
